/* core/cabe_regs.vh */
/*
 * cabe_regs.vh: instruction encodings, flag positions, flag masks and
 * cycle figures of the execution unit.
 * Assumes it is included by bare name from the core/ folder.
 */
`ifndef CABE_REGS_VH
`define CABE_REGS_VH

// ==========================================================
// major classes, instruction bits 15:12
`define CABE_MJ_RR_ARITH 4'h0
`define CABE_MJ_RR_LOGIC 4'h1
`define CABE_MJ_RR_CMP 4'h2
`define CABE_MJ_SUB_K 4'h3
`define CABE_MJ_SBC_K 4'h4
`define CABE_MJ_AND_K 4'h5
`define CABE_MJ_OR_K 4'h6
`define CABE_MJ_CMP_K 4'h7
`define CABE_MJ_CLR_K 4'h8
`define CABE_MJ_BRANCH 4'h9
`define CABE_MJ_RELATIVE_JUMP 4'ha
`define CABE_MJ_RELATIVE_SUBROUTINE_CALL 4'hb
`define CABE_MJ_BITS 4'hc
`define CABE_MJ_MISC 4'hd
`define CABE_MJ_LONG 4'he

// ==========================================================
// kinds of the bit class, bits 11:10
`define CABE_BK_REG_SKIP 2'h0
`define CABE_BK_IO_SKIP 2'h1
`define CABE_BK_IO_WRITE 2'h2
`define CABE_BK_WORD 2'h3

// ==========================================================
// functions of the misc class, bits 11:8
`define CABE_MF_POINTER_JUMP 4'h1
`define CABE_MF_POINTER_SUBROUTINE_CALL 4'h2
`define CABE_MF_RET 4'h3
`define CABE_MF_INTERRUPT_RETURN 4'h4
`define CABE_MF_SER 4'h5

// ==========================================================
// alu operations
`define CABE_ALU_ADD 3'h0
`define CABE_ALU_ADC 3'h1
`define CABE_ALU_SUB 3'h2
`define CABE_ALU_SBC 3'h3
`define CABE_ALU_AND 3'h4
`define CABE_ALU_OR 3'h5
`define CABE_ALU_EOR 3'h6

// ==========================================================
// status flag positions and update masks
`define CABE_FC 0
`define CABE_FZ 1
`define CABE_FN 2
`define CABE_FV 3
`define CABE_FS 4
`define CABE_FH 5
`define CABE_FT 6
`define CABE_FI 7
`define CABE_MASK_ARITH 8'h3f
`define CABE_MASK_LOGIC 8'h1e
`define CABE_MASK_WORD 8'h1f
`define CABE_FLAGS_RST 8'h00

// ==========================================================
// extra stall cycles beyond the first
`define CABE_XTRA_NONE 2'd0
`define CABE_XTRA_BR 2'd1
`define CABE_XTRA_JMP 2'd1
`define CABE_XTRA_CALL 2'd2
`define CABE_XTRA_RET 2'd3
`define CABE_XTRA_WORD 2'd1
`define CABE_XTRA_IOW 2'd1
`define CABE_XTRA_LONG 2'd1

// ==========================================================
// register indices and constants
`define CABE_ZL 5'd30
`define CABE_ZH 5'd31
`define CABE_WORD_BASE 5'd24
`define CABE_ALL_ONES 8'hff
`define CABE_PC_RST 16'h0000
`define CABE_IO_W 256

`endif

/* core/cabe_alu.v */
/*
 * cabe_alu.v: combinational 8-bit arithmetic and logic unit that
 * returns a result and a full status flag byte.
 * Assumes the caller merges only the flags it wants to update.
 */
`timescale 1ns/100ps
`default_nettype none
`include "cabe_regs.vh"

module cabe_alu (
	input wire [2:0] op_in,
	input wire [7:0] a_in,
	input wire [7:0] b_in,
	input wire [7:0] flags_in,
	output reg [7:0] res_out,
	output reg [7:0] flags_out
);

	wire cin;
	wire [8:0] sum;
	wire [8:0] dif;

	assign cin = (op_in == `CABE_ALU_ADC || op_in == `CABE_ALU_SBC) ?
		flags_in[`CABE_FC] : 1'b0;
	assign sum = {1'b0, a_in} + {1'b0, b_in} + {8'h00, cin};
	assign dif = {1'b0, a_in} - {1'b0, b_in} - {8'h00, cin};

	always @* begin
		flags_out = flags_in;
		res_out = 8'h00;
		case (op_in)
		`CABE_ALU_ADD, `CABE_ALU_ADC: begin
			res_out = sum[7:0];
			flags_out[`CABE_FC] = sum[8];
			flags_out[`CABE_FH] = (a_in[3] & b_in[3]) |
				(b_in[3] & ~sum[3]) | (~sum[3] & a_in[3]);
			flags_out[`CABE_FV] = (a_in[7] & b_in[7] & ~sum[7]) |
				(~a_in[7] & ~b_in[7] & sum[7]);
		end
		`CABE_ALU_SUB, `CABE_ALU_SBC: begin
			res_out = dif[7:0];
			flags_out[`CABE_FC] = dif[8];
			flags_out[`CABE_FH] = (~a_in[3] & b_in[3]) |
				(b_in[3] & dif[3]) | (dif[3] & ~a_in[3]);
			flags_out[`CABE_FV] = (a_in[7] & ~b_in[7] & ~dif[7]) |
				(~a_in[7] & b_in[7] & dif[7]);
		end
		`CABE_ALU_AND: begin
			res_out = a_in & b_in;
			flags_out[`CABE_FV] = 1'b0;
		end
		`CABE_ALU_OR: begin
			res_out = a_in | b_in;
			flags_out[`CABE_FV] = 1'b0;
		end
		`CABE_ALU_EOR: begin
			res_out = a_in ^ b_in;
			flags_out[`CABE_FV] = 1'b0;
		end
		default: begin
			res_out = 8'h00;
		end
		endcase
		// borrow chain keeps zero only if it was already zero
		if (op_in == `CABE_ALU_SBC)
			flags_out[`CABE_FZ] = (res_out == 8'h00) & flags_in[`CABE_FZ];
		else
			flags_out[`CABE_FZ] = (res_out == 8'h00);
		flags_out[`CABE_FN] = res_out[7];
		flags_out[`CABE_FS] = res_out[7] ^ flags_out[`CABE_FV];
	end

endmodule

`default_nettype wire

/* core/cabe_core.v */
/*
 * cabe_core.v: execution unit of an 8-bit core for arithmetic, logic,
 * compare, skip, jump, call, return, branch and I/O bit instructions.
 * Assumes program memory answers pmem_data_in combinationally in the
 * cycle pmem_addr_out is shown, and that io_bits_in and dbg_sel_in
 * come from logic on mclk_in.
 */
`timescale 1ns/100ps
`default_nettype none
`include "cabe_regs.vh"

module cabe_core #(
	parameter SP_W = 3
) (
	input wire mclk_in,
	input wire reset_in,
	input wire [15:0] pmem_data_in,
	input wire [`CABE_IO_W-1:0] io_bits_in,
	input wire [4:0] dbg_sel_in,
	output wire [15:0] pmem_addr_out,
	output reg exec_out,
	output reg [7:0] status_flags_out,
	output reg [4:0] io_addr_out,
	output reg [7:0] io_mask_out,
	output reg io_set_out,
	output reg io_clr_out,
	output reg [7:0] dbg_data_out
);

	localparam DEPTH = 1 << SP_W;
	localparam ST_EXEC = 2'd0;
	localparam ST_STALL = 2'd1;
	localparam ST_SKIP = 2'd2;
	localparam ST_LONG = 2'd3;

	// ==========================================================
	// state
	reg [15:0] pc;
	reg [1:0] state;
	reg [1:0] stall_cnt;
	reg [SP_W-1:0] sp;
	reg [7:0] rf [0:31];
	reg [15:0] rstk [0:DEPTH-1];
	integer i;

	// ==========================================================
	// decode fields
	wire [15:0] ir;
	wire [3:0] mj;
	wire [1:0] fn2;
	wire [4:0] rd;
	wire [4:0] rr;
	wire [4:0] rdi;
	wire [7:0] kimm;
	wire [4:0] wlo;
	wire [4:0] whi;
	wire [15:0] wval;
	wire [15:0] wres;
	wire [15:0] zptr;
	wire [SP_W-1:0] sp_top;

	assign ir = pmem_data_in;
	assign mj = ir[15:12];
	assign fn2 = ir[11:10];
	assign rd = ir[9:5];
	assign rr = ir[4:0];
	assign rdi = {1'b1, ir[11:8]};
	assign kimm = ir[7:0];
	assign wlo = `CABE_WORD_BASE + {2'b00, ir[7:6], 1'b0};
	assign whi = wlo | 5'd1;
	assign wval = {rf[whi], rf[wlo]};
	assign wres = ir[9] ? wval - {10'h000, ir[5:0]} :
		wval + {10'h000, ir[5:0]};
	assign zptr = {rf[`CABE_ZH], rf[`CABE_ZL]};
	assign sp_top = sp - 1'b1;
	assign pmem_addr_out = pc;

	// pc plus sign-extended offset plus one
	function [15:0] rel_target;
		input [15:0] p;
		input [11:0] k;
		begin
			rel_target = p + {{4{k[11]}}, k} + 16'h0001;
		end
	endfunction

	// ==========================================================
	// alu operand selection
	reg [2:0] alu_op;
	reg [7:0] alu_a;
	reg [7:0] alu_b;
	reg [7:0] flag_mask;
	reg alu_wr;
	reg [4:0] alu_wa;
	wire [7:0] alu_res;
	wire [7:0] alu_flags;
	wire [7:0] alu_merged;

	always @* begin
		alu_op = `CABE_ALU_ADD;
		alu_a = rf[rd];
		alu_b = rf[rr];
		flag_mask = 8'h00;
		alu_wr = 1'b0;
		alu_wa = rd;
		if (mj >= `CABE_MJ_SUB_K && mj <= `CABE_MJ_CLR_K) begin
			alu_a = rf[rdi];
			alu_b = kimm;
			alu_wa = rdi;
		end
		if (state == ST_EXEC) begin
			case (mj)
			`CABE_MJ_RR_ARITH: begin
				alu_op = {1'b0, fn2};
				alu_wr = 1'b1;
				flag_mask = `CABE_MASK_ARITH;
			end
			`CABE_MJ_RR_LOGIC: begin
				if (fn2 == 2'd3) begin
					alu_op = `CABE_ALU_SUB;
					flag_mask = `CABE_MASK_ARITH;
				end else begin
					// test is and with rd equal to rr
					alu_op = {1'b1, fn2};
					alu_wr = 1'b1;
					flag_mask = `CABE_MASK_LOGIC;
				end
			end
			`CABE_MJ_RR_CMP: begin
				if (fn2 == 2'd0) begin
					alu_op = `CABE_ALU_SBC;
					flag_mask = `CABE_MASK_ARITH;
				end
			end
			`CABE_MJ_SUB_K: begin
				alu_op = `CABE_ALU_SUB;
				alu_wr = 1'b1;
				flag_mask = `CABE_MASK_ARITH;
			end
			`CABE_MJ_SBC_K: begin
				alu_op = `CABE_ALU_SBC;
				alu_wr = 1'b1;
				flag_mask = `CABE_MASK_ARITH;
			end
			`CABE_MJ_AND_K: begin
				alu_op = `CABE_ALU_AND;
				alu_wr = 1'b1;
				flag_mask = `CABE_MASK_LOGIC;
			end
			`CABE_MJ_OR_K: begin
				alu_op = `CABE_ALU_OR;
				alu_wr = 1'b1;
				flag_mask = `CABE_MASK_LOGIC;
			end
			`CABE_MJ_CMP_K: begin
				alu_op = `CABE_ALU_SUB;
				flag_mask = `CABE_MASK_ARITH;
			end
			`CABE_MJ_CLR_K: begin
				alu_op = `CABE_ALU_AND;
				alu_b = `CABE_ALL_ONES - kimm;
				alu_wr = 1'b1;
				flag_mask = `CABE_MASK_LOGIC;
			end
			default: begin
				alu_wr = 1'b0;
			end
			endcase
		end
	end

	cabe_alu u_alu (
		.op_in(alu_op),
		.a_in(alu_a),
		.b_in(alu_b),
		.flags_in(status_flags_out),
		.res_out(alu_res),
		.flags_out(alu_flags)
	);

	assign alu_merged = (status_flags_out & ~flag_mask) |
		(alu_flags & flag_mask);

	// ==========================================================
	// branch condition and word flags
	reg flag_hit;
	reg [7:0] word_flags;
	wire br_go;

	always @* begin
		case (ir[10:8])
		`CABE_FC: flag_hit = status_flags_out[`CABE_FC];
		`CABE_FS: flag_hit = status_flags_out[`CABE_FN] ^
			status_flags_out[`CABE_FV];
		`CABE_FH: flag_hit = status_flags_out[`CABE_FH];
		`CABE_FT: flag_hit = status_flags_out[`CABE_FT];
		`CABE_FV: flag_hit = status_flags_out[`CABE_FV];
		`CABE_FI: flag_hit = status_flags_out[`CABE_FI];
		default: flag_hit = status_flags_out[ir[10:8]];
		endcase
	end

	// bit 11 selects the cleared form
	assign br_go = flag_hit ^ ir[11];

	always @* begin
		word_flags = status_flags_out;
		if (ir[9]) begin
			word_flags[`CABE_FV] = wval[15] & ~wres[15];
			word_flags[`CABE_FC] = wres[15] & ~wval[15];
		end else begin
			word_flags[`CABE_FV] = ~wval[15] & wres[15];
			word_flags[`CABE_FC] = ~wres[15] & wval[15];
		end
		word_flags[`CABE_FN] = wres[15];
		word_flags[`CABE_FZ] = (wres == 16'h0000);
		word_flags[`CABE_FS] = wres[15] ^ word_flags[`CABE_FV];
	end

	// ==========================================================
	// sequencing
	reg [15:0] next_pc;
	reg [1:0] next_state;
	reg [1:0] next_cnt;
	reg [7:0] next_flags;
	reg word_we;
	reg ser_we;
	reg push_en;
	reg pop_en;
	reg next_io_set;
	reg next_io_clr;

	always @* begin
		next_pc = pc + 16'h0001;
		next_state = ST_EXEC;
		next_cnt = `CABE_XTRA_NONE;
		next_flags = alu_merged;
		word_we = 1'b0;
		ser_we = 1'b0;
		push_en = 1'b0;
		pop_en = 1'b0;
		next_io_set = 1'b0;
		next_io_clr = 1'b0;
		case (state)
		ST_EXEC: begin
			case (mj)
			`CABE_MJ_RR_CMP: begin
				if (fn2 == 2'd1 && rf[rd] == rf[rr])
					next_state = ST_SKIP;
			end
			`CABE_MJ_BRANCH: begin
				if (br_go) begin
					next_pc = rel_target(pc, {{4{ir[7]}}, ir[7:0]});
					next_cnt = `CABE_XTRA_BR;
				end
			end
			`CABE_MJ_RELATIVE_JUMP: begin
				next_pc = rel_target(pc, ir[11:0]);
				next_cnt = `CABE_XTRA_JMP;
			end
			`CABE_MJ_RELATIVE_SUBROUTINE_CALL: begin
				next_pc = rel_target(pc, ir[11:0]);
				push_en = 1'b1;
				next_cnt = `CABE_XTRA_CALL;
			end
			`CABE_MJ_BITS: begin
				case (ir[11:10])
				`CABE_BK_REG_SKIP: begin
					if (rf[ir[8:4]][ir[2:0]] == ir[9])
						next_state = ST_SKIP;
				end
				`CABE_BK_IO_SKIP: begin
					if (io_bits_in[{ir[8:4], ir[2:0]}] == ir[9])
						next_state = ST_SKIP;
				end
				`CABE_BK_IO_WRITE: begin
					next_io_set = ir[9];
					next_io_clr = ~ir[9];
					next_cnt = `CABE_XTRA_IOW;
				end
				default: begin
					word_we = 1'b1;
					next_flags = word_flags;
					next_cnt = `CABE_XTRA_WORD;
				end
				endcase
			end
			`CABE_MJ_MISC: begin
				case (ir[11:8])
				`CABE_MF_POINTER_JUMP: begin
					next_pc = zptr;
					next_cnt = `CABE_XTRA_JMP;
				end
				`CABE_MF_POINTER_SUBROUTINE_CALL: begin
					next_pc = zptr;
					push_en = 1'b1;
					next_cnt = `CABE_XTRA_CALL;
				end
				`CABE_MF_RET, `CABE_MF_INTERRUPT_RETURN: begin
					next_pc = rstk[sp_top];
					pop_en = 1'b1;
					next_cnt = `CABE_XTRA_RET;
					if (ir[11:8] == `CABE_MF_INTERRUPT_RETURN)
						next_flags[`CABE_FI] = 1'b1;
				end
				`CABE_MF_SER: begin
					ser_we = 1'b1;
				end
				default: begin
					ser_we = 1'b0;
				end
				endcase
			end
			`CABE_MJ_LONG: begin
				next_state = ST_LONG;
			end
			default: begin
				next_state = ST_EXEC;
			end
			endcase
			if (next_cnt != `CABE_XTRA_NONE)
				next_state = ST_STALL;
		end
		ST_STALL: begin
			next_pc = pc;
			next_cnt = stall_cnt - 2'd1;
			if (stall_cnt != 2'd1)
				next_state = ST_STALL;
		end
		ST_SKIP: begin
			// a two-word victim costs one more cycle
			if (mj == `CABE_MJ_LONG) begin
				next_pc = pc + 16'h0002;
				next_cnt = `CABE_XTRA_LONG;
				next_state = ST_STALL;
			end
		end
		default: begin
			next_pc = ir;
			next_cnt = `CABE_XTRA_LONG;
			next_state = ST_STALL;
		end
		endcase
	end

	// ==========================================================
	// registers
	always @(posedge mclk_in) begin
		if (reset_in) begin
			pc <= `CABE_PC_RST;
			state <= ST_EXEC;
			stall_cnt <= `CABE_XTRA_NONE;
			sp <= {SP_W{1'b0}};
			exec_out <= 1'b1;
			status_flags_out <= `CABE_FLAGS_RST;
			io_addr_out <= 5'h00;
			io_mask_out <= 8'h00;
			io_set_out <= 1'b0;
			io_clr_out <= 1'b0;
			dbg_data_out <= 8'h00;
			for (i = 0; i < 32; i = i + 1)
				rf[i] <= 8'h00;
			for (i = 0; i < DEPTH; i = i + 1)
				rstk[i] <= 16'h0000;
		end else begin
			pc <= next_pc;
			state <= next_state;
			stall_cnt <= next_cnt;
			exec_out <= (next_state == ST_EXEC);
			status_flags_out <= next_flags;
			if (alu_wr)
				rf[alu_wa] <= alu_res;
			if (ser_we)
				rf[{1'b1, ir[7:4]}] <= `CABE_ALL_ONES;
			if (word_we) begin
				rf[wlo] <= wres[7:0];
				rf[whi] <= wres[15:8];
			end
			if (push_en) begin
				rstk[sp] <= pc + 16'h0001;
				sp <= sp + 1'b1;
			end
			if (pop_en)
				sp <= sp_top;
			io_set_out <= next_io_set;
			io_clr_out <= next_io_clr;
			if (next_io_set | next_io_clr) begin
				io_addr_out <= ir[8:4];
				io_mask_out <= 8'h01 << ir[2:0];
			end
			dbg_data_out <= rf[dbg_sel_in];
		end
	end

endmodule

`default_nettype wire

/* testbench/cabe_core_checker.sv */
/* checker: timing, target and flag relations of cabe_core at its ports.
   assumes one clock, mclk_in, and synchronous reset_in. */
`timescale 1ns/100ps
`default_nettype none
module cabe_core_checker #(
	parameter SP_W = 3
) (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic [15:0] pmem_data_in,
	input wire logic [255:0] io_bits_in,
	input wire logic [4:0] dbg_sel_in,
	input wire logic [15:0] pmem_addr_out,
	input wire logic exec_out,
	input wire logic [7:0] status_flags_out,
	input wire logic [4:0] io_addr_out,
	input wire logic [7:0] io_mask_out,
	input wire logic io_set_out,
	input wire logic io_clr_out,
	input wire logic [7:0] dbg_data_out
);
// ==========
// decode helpers
wire [3:0] mj = pmem_data_in[15:12];
wire [15:0] brk = {{8{pmem_data_in[7]}}, pmem_data_in[7:0]};
wire [15:0] rk = {{4{pmem_data_in[11]}}, pmem_data_in[11:0]};
wire [2:0] fs = pmem_data_in[10:8];
wire [7:0] f = status_flags_out;
wire fl = (fs == 3'h4) ? f[2] ^ f[3] : f[fs];
wire take = fl ^ pmem_data_in[11];
wire io_hit = io_bits_in[{pmem_data_in[8:4], pmem_data_in[2:0]}]
	== pmem_data_in[9];
wire lg = (mj == 4'h1 && pmem_data_in[11:10] != 2'h3) || mj == 4'h5
	|| mj == 4'h6 || mj == 4'h8;
wire bx = exec_out && mj == 4'hc;
default clocking cb @(posedge mclk_in);
endclocking
default disable iff (reset_in);
// ==========
// assertions
chk_branch_taken: assert property (exec_out && mj == 4'h9 && take |=>
	pmem_addr_out == $past(pmem_addr_out) + $past(brk) + 16'h0001
	&& !exec_out ##1 exec_out) else $error("taken branch wrong");
chk_branch_idle: assert property (exec_out && mj == 4'h9 && !take |=>
	pmem_addr_out == $past(pmem_addr_out) + 16'h0001 && exec_out)
	else $error("untaken branch wrong");
chk_branch_keep: assert property (exec_out && mj == 4'h9 |=>
	$stable(status_flags_out)) else $error("branch changed flags");
chk_call_span: assert property (exec_out && mj == 4'hb |=>
	pmem_addr_out == $past(pmem_addr_out) + $past(rk) + 16'h0001
	&& !exec_out ##1 !exec_out ##1 exec_out) else $error("call wrong");
chk_pjump_span: assert property (exec_out && mj == 4'hd
	&& pmem_data_in[11:8] == 4'h1 |=> !exec_out ##1 exec_out
	&& $stable(status_flags_out)) else $error("pointer jump span");
chk_pcall_span: assert property (exec_out && mj == 4'hd
	&& pmem_data_in[11:8] == 4'h2 |=> !exec_out[*2] ##1 exec_out)
	else $error("pointer call span");
chk_io_pulse: assert property (bx && pmem_data_in[11:10] == 2'h2 |=>
	io_set_out == $past(pmem_data_in[9]) && io_clr_out != io_set_out
	&& io_addr_out == $past(pmem_data_in[8:4])
	&& io_mask_out == 8'h01 << $past(pmem_data_in[2:0]) && !exec_out
	##1 exec_out && !io_set_out && !io_clr_out) else $error("io write");
chk_io_skip: assert property (bx && pmem_data_in[11:10] == 2'h1 |=>
	exec_out == !$past(io_hit)) else $error("io skip decision");
chk_word_span: assert property (bx && pmem_data_in[11:10] == 2'h3 |=>
	!exec_out ##1 exec_out) else $error("word op span");
chk_logic_flags: assert property (exec_out && lg |=> !f[3]
	&& f[4] == f[2] && f[0] == $past(f[0]) && f[5] == $past(f[5]))
	else $error("logic flags");
endmodule
bind cabe_core cabe_core_checker #(.SP_W(SP_W)) cabe_core_checker_inst (
	.mclk_in(mclk_in), .reset_in(reset_in), .pmem_data_in(pmem_data_in),
	.io_bits_in(io_bits_in), .dbg_sel_in(dbg_sel_in),
	.pmem_addr_out(pmem_addr_out), .exec_out(exec_out),
	.status_flags_out(status_flags_out), .io_addr_out(io_addr_out),
	.io_mask_out(io_mask_out), .io_set_out(io_set_out),
	.io_clr_out(io_clr_out), .dbg_data_out(dbg_data_out));
`default_nettype wire

/* testbench/cabe_pmem.sv */
/* program memory model for cabe_core: 64 words, answers combinationally.
   assumes the bench loads words by hierarchy while the core is in reset. */
`timescale 1ns/100ps
`default_nettype none
module cabe_pmem (
	input wire logic [15:0] addr_in,
	output logic [15:0] data_out
);
logic [15:0] words [0:63];
// outside the array, a jump to itself
assign data_out = addr_in < 16'h0040 ? words[addr_in[5:0]] : 16'hafff;
endmodule
`default_nettype wire

/* testbench/tb.sv */
/* self-checking bench for cabe_core: short programs run from cabe_pmem,
   results read back through the debug port, the flag and pc outputs and the io pulses. */
`timescale 1ns/100ps
`default_nettype none
module tb;
typedef struct packed {int kind; logic [15:0] val;} cabe_note_t;
logic mclk_in, reset_in, look, v, sk;
logic [255:0] io_bits_in;
logic [4:0] dbg_sel_in, ad;
wire logic [15:0] pmem_data_in, pmem_addr_out;
wire logic exec_out, io_set_out, io_clr_out;
wire logic [7:0] status_flags_out, io_mask_out, dbg_data_out;
wire logic [4:0] io_addr_out;
int miscompares, check_count;
cabe_note_t notes[$];
cabe_note_t n;
int j;
logic [15:0] seen, rf, w;
logic [7:0] a, b, pf, ef, m;
logic [2:0] bt;
string what[4] = '{"reg", "flags", "pc", "io"};
int op[16] = '{0, 1, 2, 3, 4, 5, 6, 2, 3, 4, 2, 3, 4, 5, 2, 4};
logic [15:0] aw[16] = '{16'h0211, 16'h0611, 16'h0a11, 16'h0e11,
	16'h1211, 16'h1611, 16'h1a11, 16'h1e11, 16'h2211, 16'h1210,
	16'h3000, 16'h4000, 16'h5000, 16'h6000, 16'h7000, 16'h8000};
cabe_core #(.SP_W(3)) cabe_core_inst (.mclk_in(mclk_in), .reset_in(reset_in),
	.pmem_data_in(pmem_data_in), .io_bits_in(io_bits_in),
	.dbg_sel_in(dbg_sel_in), .pmem_addr_out(pmem_addr_out),
	.exec_out(exec_out), .status_flags_out(status_flags_out),
	.io_addr_out(io_addr_out), .io_mask_out(io_mask_out),
	.io_set_out(io_set_out), .io_clr_out(io_clr_out),
	.dbg_data_out(dbg_data_out));
cabe_pmem cabe_pmem_inst (.addr_in(pmem_addr_out), .data_out(pmem_data_in));
// ==========
// reference and drivers
function automatic logic [15:0] alu_ref(input int o,
	input logic [7:0] x, y, p);
	logic [8:0] r;
	logic [7:0] f;
	logic c;
	f = 8'h00;
	c = (o == 1 || o == 3) & p[0];
	case (o)
	0, 1: r = {1'b0, x} + {1'b0, y} + {8'h00, c};
	2, 3: r = {1'b0, x} - {1'b0, y} - {8'h00, c};
	4: r = {1'b0, x & y};
	5: r = {1'b0, x | y};
	default: r = {1'b0, x ^ y};
	endcase
	f[0] = r[8];
	// borrow chain keeps zero only if it was already zero
	f[1] = r[7:0] == 8'h00 && (o != 3 || p[1]);
	f[2] = r[7];
	if (o < 2) begin
		f[3] = x[7] & y[7] & ~r[7] | ~x[7] & ~y[7] & r[7];
		f[5] = x[3] & y[3] | y[3] & ~r[3] | ~r[3] & x[3];
	end
	if (o == 2 || o == 3) begin
		f[3] = x[7] & ~y[7] & ~r[7] | ~x[7] & y[7] & r[7];
		f[5] = ~x[3] & y[3] | y[3] & r[3] | r[3] & ~x[3];
	end
	f[4] = f[2] ^ f[3];
	return {f, r[7:0]};
endfunction
task start();
	@(posedge mclk_in);
	reset_in <= 1'b1;
	for (j = 0; j < 64; j++)
		cabe_pmem_inst.words[j] <= 16'hafff;
endtask
task put(input int p, input logic [15:0] wd);
	cabe_pmem_inst.words[p] <= wd;
endtask
task automatic go();
	repeat (2) @(posedge mclk_in);
	reset_in <= 1'b0;
	repeat (30) @(posedge mclk_in);
endtask
task automatic want(input int k, input logic [4:0] s, input logic [15:0] x);
	dbg_sel_in <= s;
	repeat (2) @(posedge mclk_in);
	notes.push_back('{k, x});
	look <= 1'b1;
	@(posedge mclk_in);
	look <= 1'b0;
endtask
task automatic close_out();
	if (notes.size() != 0)
		miscompares++;
	$display("checks %0d mismatches %0d", check_count, miscompares);
	if (miscompares == 0 && check_count > 0)
		$display("Regression OK");
	else
		$display("Regression broken");
	$finish;
endtask
// ==========
// monitor
always @(negedge mclk_in) if (look || io_set_out || io_clr_out) begin
	if (notes.size() == 0)
		n = '{9, 16'h0000};
	else
		n = notes.pop_front();
	case (n.kind)
	0: seen = {8'h00, dbg_data_out};
	1: seen = {8'h00, status_flags_out};
	2: seen = pmem_addr_out;
	default: seen = {1'b0, io_set_out, io_clr_out, io_addr_out, io_mask_out};
	endcase
	check_count++;
	if (n.kind > 3 || seen !== n.val) begin
		miscompares++;
		$display("[ERR] %s expected %h seen %h", what[n.kind & 3], n.val, seen);
	end
end
initial begin
	mclk_in = 1'b0;
	forever #4 mclk_in = ~mclk_in;
end
initial begin
	#100000;
	miscompares++;
	close_out();
end
// ==========
// scenarios
initial begin
	reset_in = 1'b1;
	look = 1'b0;
	io_bits_in = 256'h0;
	dbg_sel_in = 5'h00;
	miscompares = 0;
	check_count = 0;
	void'($urandom(95));
	repeat (2) @(posedge mclk_in);
	for (int i = 0; i < 16; i++) begin
		a = $urandom();
		b = $urandom();
		start();
		put(0, {8'h30, 8'h00 - a});
		put(1, {8'h31, 8'h00 - b});
		put(2, i > 9 ? aw[i] | {8'h00, b} : aw[i]);
		go();
		rf = alu_ref(2, 8'h00, 8'h00 - b, 8'h00);
		pf = rf[15:8];
		rf = alu_ref(op[i], a, i == 9 ? a : i == 15 ? 8'hff - b : b, pf);
		m = op[i] > 3 ? 8'h1e : 8'h3f;
		ef = rf[15:8] & m | pf & ~m;
		w = {8'h00, i == 7 || i == 8 || i == 14 ? a : rf[7:0]};
		want(0, 5'h10, w);
		want(1, 5'h00, {8'h00, ef});
	end
	a = $urandom() | 8'hc0;
	b = $urandom();
	start();
	put(0, {8'h38, 8'h00 - a});
	put(1, {8'hcc, 2'b00, b[5:0]});
	go();
	rf = {8'h00, a} + {10'h000, b[5:0]};
	want(0, 5'h18, {8'h00, rf[7:0]});
	want(0, 5'h19, {8'h00, rf[15:8]});
	for (int s = 0; s < 16; s++) begin
		a = $urandom();
		start();
		put(0, {8'h30, a});
		put(1, {4'h9, s[3:0], 8'h02});
		go();
		rf = alu_ref(2, 8'h00, a, 8'h00);
		pf = rf[15:8];
		v = s[2:0] == 3'h4 ? pf[2] ^ pf[3] : pf[s[2:0]];
		w = v ^ s[3] ? 16'h0004 : 16'h0002;
		want(2, 5'h00, w);
		want(1, 5'h00, {8'h00, pf});
	end
	start();
	put(0, 16'hb004);
	go();
	want(2, 5'h00, 16'h0005);
	start();
	put(0, 16'h3ef9);
	put(1, 16'hd100);
	go();
	want(2, 5'h00, 16'h0007);
	start();
	put(0, 16'h3ef8);
	put(1, 16'hd200);
	put(2, 16'hd500);
	put(8, 16'hb003);
	put(9, 16'hd400);
	put(12, 16'hd300);
	go();
	rf = alu_ref(2, 8'h00, 8'hf8, 8'h00);
	want(2, 5'h00, 16'h0003);
	want(0, 5'h10, 16'h00ff);
	want(1, 5'h00, {8'h00, rf[15:8] | 8'h80});
	for (int i = 0; i < 12; i++) begin
		a = $urandom();
		b = i % 2 ? a : $urandom();
		bt = $urandom();
		ad = $urandom();
		v = $urandom();
		start();
		io_bits_in <= {8{$urandom()}};
		put(0, {8'h30, 8'h00 - a});
		put(1, {8'h31, 8'h00 - b});
		w = {4'hc, 1'b0, i % 3 == 2, v, i % 3 == 2 ? ad : 5'h10, 1'b0, bt};
		put(2, i % 3 == 0 ? 16'h2611 : w);
		if (i > 5) begin
			put(3, 16'he000);
			put(4, 16'h0009);
		end
		go();
		sk = i % 3 == 0 ? a == b : i % 3 == 1 ? a[bt] == v
			: io_bits_in[{ad, bt}] == v;
		w = i > 5 ? (sk ? 16'h0005 : 16'h0009) : (sk ? 16'h0004 : 16'h0003);
		want(2, 5'h00, w);
	end
	for (int i = 0; i < 4; i++) begin
		ad = $urandom();
		bt = $urandom();
		v = i[0];
		start();
		put(0, {4'hc, 2'b10, v, ad, 1'b0, bt});
		put(1, {4'hc, 2'b10, ~v, ad, 1'b0, bt + 3'h1});
		notes.push_back('{3, {1'b0, v, ~v, ad, 8'h01 << bt}});
		notes.push_back('{3, {1'b0, ~v, v, ad, 8'h01 << (bt + 3'h1)}});
		go();
	end
	close_out();
end
endmodule
`default_nettype wire
